// ### pkg/rfr_pkg.sv
// Purpose: shared constants and types for the reading filter and rounding block
// Assumes: readings are signed counts of the display, one system clock
// Notes:   codes index the selectable steps and depths, not the printed figures
package rfr_pkg;

  // menu walk, gray coded along the accept path from RUN through SETPT to RESET
  typedef enum logic [2:0] {
    RFR_RUN   = 3'b000,
    RFR_POINT = 3'b001,
    RFR_STEP  = 3'b011,
    RFR_FILT  = 3'b010,
    RFR_DEPTH = 3'b110,
    RFR_SETPT = 3'b111,
    RFR_RESET = 3'b101
  } rfr_menu_t;

  localparam logic [2:0]  POS_DEFAULT   = 3'h0;   // point after last digit
  localparam logic [2:0]  POS_LAST      = 3'h5;   // six positions, 0..5
  localparam logic [2:0]  STEP_DEFAULT  = 3'h0;   // code 0 = one count
  localparam logic [2:0]  STEP_LAST     = 3'h6;   // seven steps, 0..6
  localparam logic [2:0]  DEPTH_DEFAULT = 3'h6;   // 2**6 = 64 readings
  localparam logic        TYPE_DEFAULT  = 1'h0;   // adaptive
  localparam logic        DISP_DEFAULT  = 1'h1;   // filtered
  localparam logic [1:0]  AOUT_DEFAULT  = 2'h1;   // filtered
  localparam logic [1:0]  FIELD_LAST    = 2'h2;   // three filter settings
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  ERR_OFFSET    = 8'h01;  // offset outside display
  localparam int          DISPLAY_MAX   = 999999; // largest displayable magnitude

  // count-by step in display counts for a step code
  function automatic logic [6:0] rfr_step_counts(input logic [2:0] code);
    case (code)
      3'h0:    return 7'h01;
      3'h1:    return 7'h02;
      3'h2:    return 7'h05;
      3'h3:    return 7'h0a;
      3'h4:    return 7'h14;
      3'h5:    return 7'h32;
      default: return 7'h64;
    endcase
  endfunction : rfr_step_counts

endpackage : rfr_pkg

// ### pkg/rfr_stream_if.sv
// Purpose: valid/ready word stream between the filter core and its buffer
// Assumes: one clock, a word moves when valid and ready are both high
// Notes:   src drives the words, snk takes them
`timescale 1ns/100ps
interface rfr_stream_if #(parameter int W = 24);
  logic         valid;  // word offered
  logic         ready;  // word can be taken
  logic [W-1:0] data;   // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rfr_stream_if

// ### core/rfr_fifo.sv
// Purpose: sample buffer in front of the filter
// Assumes: DEPTH is a power of two
// Notes:   ready on the write side is registered, so it lags a pop by one cycle
`timescale 1ns/100ps
module rfr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
)(
  input wire logic core_clk,
  input wire logic rst_n,
  rfr_stream_if.snk wr,
  rfr_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // word store
  logic [AW-1:0]    wrPtr_reg;    // next slot to fill
  logic [AW-1:0]    rdPtr_reg;    // oldest word
  logic [AW:0]      count_reg;    // words held
  logic [AW:0]      count_next;
  logic             ready_reg;    // room for one more
  logic             push;
  logic             pop;

  assign push     = wr.valid && ready_reg;
  assign pop      = rd.valid && rd.ready;
  assign wr.ready = ready_reg;
  assign rd.valid = (count_reg != '0);
  assign rd.data  = mem[rdPtr_reg];

  // occupancy, both sides may move in one cycle
  always_comb begin
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // storage, no reset needed on the data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= wr.data;
    end
  end

  // pointers and level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_reg + AW'(push);
      rdPtr_reg <= rdPtr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end

endmodule : rfr_fifo

// ### core/rfr_reading_filter.sv
// Purpose: averaging, count-by rounding, point position and source selection
// Assumes: readings arrive on core_clk; buttons are raw pins; depth codes 0..7
// Notes:   samples are held in the buffer while a menu is open
// Behaviour
// - six point positions, default after last digit
// - offset outside display range shows error 01
// - point menu: fill F's, move point, accept
// - round display to nearest count-by multiple
// - count-by step defaults to one count
// - count-by accept stores, goes to filter menu
// - filter type 0 adaptive, 1 moving average
// - adaptive averages steady input, drops on jumps
// - adaptive depth is the maximum averaged count
// - moving average uses exactly configured count
// - display source 0 raw, 1 filtered
// - analog source 0 raw, 1 filtered default
// - analog source 2 peak, 3 valley
// - filter menu cycles settings, accept stores all
// - depth 1..128 in powers of two, default 64
// - depth accept goes setpoints or reset then run
// - point change rescales offset, overflow flashes 999999
`timescale 1ns/100ps
module rfr_reading_filter #(
  parameter int DATA_W     = 24,
  parameter int FIFO_DEPTH = 32,
  parameter int ADAPT_BAND = 16
)(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     stepBtn,
  input  wire logic                     changeBtn,
  input  wire logic                     acceptBtn,
  input  wire logic                     setupUnlocked,
  input  wire logic                     sampleValid,
  input  wire logic signed [DATA_W-1:0] sampleData,
  output logic                          sampleReady,
  input  wire logic                     offsetLoad,
  input  wire logic signed [DATA_W-1:0] readingOffsetValue,
  output logic [2:0]                    menuState,
  output logic                          fillDigits,
  output logic [2:0]                    pointPosition,
  output logic [2:0]                    roundingStep,
  output logic                          filterTypeSel,
  output logic                          displaySourceSel,
  output logic [1:0]                    analogOutSourceSel,
  output logic [2:0]                    averagingDepth,
  output logic [7:0]                    errorCode,
  output logic                          offsetFlash,
  output logic signed [DATA_W-1:0]      offsetScaled,
  output logic                          displayValid,
  output logic signed [DATA_W-1:0]      displayValue,
  output logic                          analogValid,
  output logic signed [DATA_W-1:0]      analogValue
);
  localparam int SW = DATA_W + 8;  // room for 128 summed readings
  localparam logic signed [SW-1:0] DMAX = SW'(rfr_pkg::DISPLAY_MAX);
  localparam logic signed [SW-1:0] TEN  = SW'(10);
  localparam logic signed [SW-1:0] BAND = SW'(ADAPT_BAND);

  // clamp to the displayable range
  function automatic logic signed [SW-1:0] satDisp(input logic signed [SW-1:0] v);
    if (v > DMAX) return DMAX;
    if (v < -DMAX) return -DMAX;
    return v;
  endfunction : satDisp

  // magnitude of a wide signed value
  function automatic logic signed [SW-1:0] absWide(input logic signed [SW-1:0] v);
    return (v < 0) ? -v : v;
  endfunction : absWide

  // nearest multiple of the step, halves away from zero
  function automatic logic signed [SW-1:0] roundStep(input logic signed [SW-1:0] v,
                                                     input logic [2:0] code);
    logic [SW-1:0] m;
    logic [SW-1:0] s;
    logic [SW-1:0] r;
    m = absWide(v);
    s = SW'(rfr_pkg::rfr_step_counts(code));
    r = ((m + (s >> 1)) / s) * s;
    return (v < 0) ? -$signed(r) : $signed(r);
  endfunction : roundStep

  // pin synchronisers: step, change, accept, unlock
  logic [3:0] pinMeta_reg;  // first stage, read only by the second
  logic [3:0] pinSync_reg;  // safe copies
  logic [2:0] btnPrev_reg;  // for press edges
  logic       stepRise;
  logic       changeRise;
  logic       acceptRise;

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pinMeta_reg[i] <= 1'b0;
        pinSync_reg[i] <= 1'b0;
      end else begin
        pinMeta_reg[i] <= (i == 0) ? stepBtn : (i == 1) ? changeBtn :
                          (i == 2) ? acceptBtn : setupUnlocked;
        pinSync_reg[i] <= pinMeta_reg[i];
      end
    end
  end

  // press edges, one pulse per press
  always_ff @(posedge core_clk) begin
    if (!rst_n) btnPrev_reg <= 3'h0;
    else btnPrev_reg <= pinSync_reg[2:0];
  end
  assign stepRise   = pinSync_reg[0] && !btnPrev_reg[0];
  assign changeRise = pinSync_reg[1] && !btnPrev_reg[1];
  assign acceptRise = pinSync_reg[2] && !btnPrev_reg[2];

  // menu state
  rfr_pkg::rfr_menu_t state_reg;
  logic               clearReq;  // new filter settings stored

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= rfr_pkg::RFR_RUN;
    end else if (acceptRise) begin
      unique case (state_reg)
        rfr_pkg::RFR_RUN:   state_reg <= rfr_pkg::RFR_POINT;
        rfr_pkg::RFR_POINT: state_reg <= rfr_pkg::RFR_STEP;
        rfr_pkg::RFR_STEP:  state_reg <= rfr_pkg::RFR_FILT;
        rfr_pkg::RFR_FILT:  state_reg <= rfr_pkg::RFR_DEPTH;
        rfr_pkg::RFR_DEPTH: state_reg <= pinSync_reg[3] ? rfr_pkg::RFR_SETPT
                                                         : rfr_pkg::RFR_RESET;
        rfr_pkg::RFR_SETPT: state_reg <= rfr_pkg::RFR_RESET;
        rfr_pkg::RFR_RESET: state_reg <= rfr_pkg::RFR_RUN;
        default:            state_reg <= rfr_pkg::RFR_RUN;  // illegal code 100
      endcase
    end
  end
  assign clearReq = acceptRise && (state_reg == rfr_pkg::RFR_FILT ||
                                   state_reg == rfr_pkg::RFR_DEPTH);

  // stored and pending settings
  logic [2:0] pos_reg, pendPos;        // point position
  logic [2:0] step_reg, stepShow, pendStep;  // count-by codes
  logic       type_reg, pendType;      // filter type
  logic       disp_reg, pendDisp;      // display source
  logic [1:0] aout_reg, pendAout;      // analog source
  logic [1:0] field_reg;               // filter setting under edit
  logic [2:0] depth_reg, depthShow, pendDepth;  // depth codes
  logic       fill_reg;                // all digits shown as F

  // pending edits reload from the stored values at reset and while in RUN
  always_ff @(posedge core_clk) begin
    if (!rst_n || state_reg == rfr_pkg::RFR_RUN) begin
      pendPos <= pos_reg;  stepShow <= step_reg;  pendStep <= step_reg;
      pendType <= type_reg;  pendDisp <= disp_reg;  pendAout <= aout_reg;
      field_reg <= 2'h0;  depthShow <= depth_reg;  pendDepth <= depth_reg;
      fill_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        rfr_pkg::RFR_POINT: begin
          if (stepRise) fill_reg <= 1'b1;
          if (changeRise) pendPos <= (pendPos == rfr_pkg::POS_LAST) ? 3'h0 : pendPos + 3'h1;
        end
        rfr_pkg::RFR_STEP: begin
          fill_reg <= 1'b0;
          if (stepRise) stepShow <= (stepShow == rfr_pkg::STEP_LAST) ? 3'h0 : stepShow + 3'h1;
          if (changeRise) pendStep <= stepShow;
        end
        rfr_pkg::RFR_FILT: begin
          if (stepRise) field_reg <= (field_reg == rfr_pkg::FIELD_LAST) ? 2'h0 : field_reg + 2'h1;
          if (changeRise && field_reg == 2'h0) pendType <= !pendType;
          if (changeRise && field_reg == 2'h1) pendDisp <= !pendDisp;
          if (changeRise && field_reg == 2'h2) pendAout <= pendAout + 2'h1;
        end
        rfr_pkg::RFR_DEPTH: begin
          if (stepRise) depthShow <= depthShow + 3'h1;
          if (changeRise) pendDepth <= depthShow;
        end
        default: fill_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pos_reg   <= rfr_pkg::POS_DEFAULT;
      step_reg  <= rfr_pkg::STEP_DEFAULT;
      type_reg  <= rfr_pkg::TYPE_DEFAULT;
      disp_reg  <= rfr_pkg::DISP_DEFAULT;
      aout_reg  <= rfr_pkg::AOUT_DEFAULT;
      depth_reg <= rfr_pkg::DEPTH_DEFAULT;
    end else if (acceptRise) begin
      if (state_reg == rfr_pkg::RFR_POINT) pos_reg <= pendPos;
      if (state_reg == rfr_pkg::RFR_STEP) step_reg <= pendStep;
      if (state_reg == rfr_pkg::RFR_FILT) begin
        type_reg <= pendType;
        disp_reg <= pendDisp;
        aout_reg <= pendAout;
      end
      if (state_reg == rfr_pkg::RFR_DEPTH) depth_reg <= pendDepth;
    end
  end

  // offset copy at the current point position
  logic signed [SW-1:0] offset_reg;
  logic signed [3:0]    shift_reg;   // decades still to apply
  logic [7:0]           err_reg;
  logic                 flash_reg;
  logic signed [SW-1:0] offsetTimes;

  assign offsetTimes = offset_reg * TEN;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      offset_reg <= '0;
      shift_reg  <= 4'sh0;
      err_reg    <= rfr_pkg::ERR_NONE;
      flash_reg  <= 1'b0;
    end else begin
      if (offsetLoad) begin
        offset_reg <= satDisp(SW'(readingOffsetValue));
        flash_reg  <= 1'b0;
        err_reg <= (absWide(SW'(readingOffsetValue)) > DMAX) ? rfr_pkg::ERR_OFFSET
                                                            : rfr_pkg::ERR_NONE;
      end else if (shift_reg > 0) begin
        shift_reg <= shift_reg - 4'sh1;
        offset_reg <= satDisp(offsetTimes);
        if (absWide(offsetTimes) > DMAX) flash_reg <= 1'b1;
      end else if (shift_reg < 0) begin
        shift_reg <= shift_reg + 4'sh1;
        offset_reg <= offset_reg / TEN;
      end
      // armed apart from the load, so a load in the same cycle still gets rescaled
      if (acceptRise && state_reg == rfr_pkg::RFR_POINT) begin
        shift_reg <= $signed({1'b0, pendPos}) - $signed({1'b0, pos_reg});
      end
    end
  end

  // sample buffer, drained only while running
  rfr_stream_if #(.W(DATA_W)) inIf ();
  rfr_stream_if #(.W(DATA_W)) outIf ();
  assign inIf.valid  = sampleValid;
  assign inIf.data   = sampleData;
  assign outIf.ready = (state_reg == rfr_pkg::RFR_RUN);

  rfr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr       (inIf.snk),
    .rd       (outIf.src)
  );

  // averaging history and window
  logic signed [DATA_W-1:0] hist [128];  // last readings
  logic [6:0]               wrPtr_reg;
  logic [7:0]               cnt_reg;     // readings since restart, capped
  logic [2:0]               k_reg;       // window is 2**k readings
  logic signed [SW-1:0]     sumWin_reg, sumAll_reg;
  logic signed [SW-1:0]     x, oldest, filtNow, sumAllNext;
  logic                     take, jump;

  assign take       = outIf.valid && outIf.ready;
  assign x          = SW'($signed(outIf.data));
  assign oldest     = SW'(hist[wrPtr_reg - (7'h1 << k_reg)]);
  assign filtNow    = sumWin_reg >>> k_reg;
  assign sumAllNext = sumAll_reg + x;
  // type selects adaptive; jump restarts window
  assign jump = !type_reg && cnt_reg != 8'h0 && absWide(x - filtNow) > BAND;

  // history store
  always_ff @(posedge core_clk) begin
    if (take) hist[wrPtr_reg] <= outIf.data;
  end

  // window sums; cleared with new settings
  always_ff @(posedge core_clk) begin
    if (!rst_n || clearReq) begin
      wrPtr_reg <= 7'h0;  cnt_reg <= 8'h0;  k_reg <= 3'h0;
      sumWin_reg <= '0;  sumAll_reg <= '0;
    end else if (take) begin
      wrPtr_reg <= wrPtr_reg + 7'h1;
      if (jump) begin
        k_reg <= 3'h0;  cnt_reg <= 8'h1;  sumWin_reg <= x;  sumAll_reg <= x;
      end else begin
        sumAll_reg <= sumAllNext;
        if (cnt_reg != 8'h80) cnt_reg <= cnt_reg + 8'h1;
        // window grows up to the depth
        if (k_reg < depth_reg && cnt_reg + 8'h1 == (8'h2 << k_reg)) begin
          k_reg <= k_reg + 3'h1;
          sumWin_reg <= sumAllNext;
        end else if (cnt_reg < (8'h1 << k_reg)) begin
          sumWin_reg <= sumWin_reg + x;
        end else begin
          sumWin_reg <= sumWin_reg + x - oldest;
        end
      end
    end
  end

  // stage behind the window update
  logic                     s1Valid_reg;
  logic signed [DATA_W-1:0] raw_reg, peak_reg, valley_reg;
  logic                     trackValid_reg;
  logic                     filtReady;

  // moving average waits for a full window
  assign filtReady = !type_reg || k_reg == depth_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n || clearReq) begin
      s1Valid_reg <= 1'b0;  raw_reg <= '0;  trackValid_reg <= 1'b0;
      peak_reg <= '0;  valley_reg <= '0;
    end else begin
      s1Valid_reg <= take;
      if (take) begin
        raw_reg <= outIf.data;
        trackValid_reg <= 1'b1;
        if (!trackValid_reg || $signed(outIf.data) > peak_reg) peak_reg <= outIf.data;
        if (!trackValid_reg || $signed(outIf.data) < valley_reg) valley_reg <= outIf.data;
      end
    end
  end

  // outputs for display and analog path
  logic                     dispV_reg, aoutV_reg;
  logic signed [DATA_W-1:0] dispVal_reg, aoutVal_reg;
  logic signed [SW-1:0]     dispPick;

  assign dispPick = disp_reg ? filtNow : SW'(raw_reg);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dispV_reg <= 1'b0;  aoutV_reg <= 1'b0;  dispVal_reg <= '0;  aoutVal_reg <= '0;
    end else begin
      dispV_reg <= s1Valid_reg && (!disp_reg || filtReady);
      aoutV_reg <= s1Valid_reg && (aout_reg != 2'h1 || filtReady);
      if (s1Valid_reg) dispVal_reg <= DATA_W'(satDisp(roundStep(dispPick, step_reg)));
      if (s1Valid_reg) begin
        unique case (aout_reg)
          2'h0: aoutVal_reg <= raw_reg;
          2'h1: aoutVal_reg <= DATA_W'(filtNow);
          2'h2: aoutVal_reg <= peak_reg;
          2'h3: aoutVal_reg <= valley_reg;
        endcase
      end
    end
  end

  assign sampleReady        = inIf.ready;
  assign menuState          = state_reg;
  assign fillDigits         = fill_reg;
  assign pointPosition      = pos_reg;
  assign roundingStep       = step_reg;
  assign filterTypeSel      = type_reg;
  assign displaySourceSel   = disp_reg;
  assign analogOutSourceSel = aout_reg;
  assign averagingDepth     = depth_reg;
  assign errorCode          = err_reg;
  assign offsetFlash        = flash_reg;
  assign offsetScaled       = DATA_W'(offset_reg);
  assign displayValid       = dispV_reg;
  assign displayValue       = dispVal_reg;
  assign analogValid        = aoutV_reg;
  assign analogValue        = aoutVal_reg;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence pointAccept;
    acceptRise && state_reg == rfr_pkg::RFR_POINT;
  endsequence
  sequence stepAccept;
    acceptRise && state_reg == rfr_pkg::RFR_STEP;
  endsequence

  a_point_range: assert property (pos_reg <= rfr_pkg::POS_LAST)
    else $error("point position out of range");
  a_offset_error: assert property (offsetLoad && absWide(SW'(readingOffsetValue)) > DMAX
    |=> err_reg == rfr_pkg::ERR_OFFSET) else $error("offset error not raised");
  a_point_store: assert property (pointAccept |=>
    state_reg == rfr_pkg::RFR_STEP && pos_reg == $past(pendPos)) else $error("point not stored");
  a_round_multiple: assert property (dispV_reg && absWide(SW'(dispVal_reg)) != DMAX
    |-> absWide(SW'(dispVal_reg)) % SW'(rfr_pkg::rfr_step_counts(step_reg)) == 0)
    else $error("display not a step multiple");
  a_step_store: assert property (stepAccept |=>
    state_reg == rfr_pkg::RFR_FILT && step_reg == $past(pendStep)) else $error("step not stored");
  a_jump_drop: assert property (take && jump && !clearReq |=> k_reg == 3'h0)
    else $error("adaptive window kept on jump");
  a_ma_exact: assert property (s1Valid_reg && type_reg && disp_reg ##1 dispV_reg
    |-> $past(k_reg) == $past(depth_reg)) else $error("short moving average shown");
  a_depth_next: assert property (acceptRise && state_reg == rfr_pkg::RFR_DEPTH |=>
    state_reg == ($past(pinSync_reg[3]) ? rfr_pkg::RFR_SETPT : rfr_pkg::RFR_RESET))
    else $error("wrong menu after depth");
  a_offset_sat: assert property (absWide(offset_reg) <= DMAX)
    else $error("offset exceeds display range");
  a_filter_clear: assert property (clearReq |=> cnt_reg == 8'h0 ##1 !trackValid_reg || take)
    else $error("history not cleared");

endmodule : rfr_reading_filter

// ### dv/rfr_panel_model.sv
// Purpose: front panel buttons and converter reading source
// Assumes: buttons are held two edges, readings wait for sampleReady
// Notes:   released data lines show the inverse, never the last word
`timescale 1ns/100ps
module rfr_panel_model #(
  parameter int W = 24
)(
  input  wire logic           core_clk,
  input  wire logic           sampleReady,
  output logic                stepBtn,
  output logic                changeBtn,
  output logic                acceptBtn,
  output logic                sampleValid,
  output logic signed [W-1:0] sampleData
);
  // idle panel: nothing pressed, nothing offered
  initial begin
    {acceptBtn, changeBtn, stepBtn} = 3'h0;
    sampleValid = 1'b0;
    sampleData  = '0;
  end

  // one press: 0 step, 1 change, 2 accept; long gap covers the synchroniser
  task automatic press(input int b);
    @(posedge core_clk);
    #2;
    {acceptBtn, changeBtn, stepBtn} = 3'(1 << b);
    repeat (2) @(posedge core_clk);
    #2;
    {acceptBtn, changeBtn, stepBtn} = 3'h0;
    repeat (5) @(posedge core_clk);
    #2;
  endtask : press

  // one reading, held until an edge sees ready high
  task automatic send(input logic signed [W-1:0] v);
    @(posedge core_clk);
    #2;
    sampleValid = 1'b1;
    sampleData  = v;
    // ready only moves on edges, so high now means high at the next edge
    while (sampleReady !== 1'b1) begin
      @(posedge core_clk);
      #2;
    end
    @(posedge core_clk);
    #2;
    sampleValid = 1'b0;
    sampleData  = ~v;
  endtask : send
endmodule : rfr_panel_model

// ### dv/rfr_reading_filter_tb_top.sv
// Purpose: bench for menus, rounding, averaging and the sample buffer
// Assumes: panel model drives buttons and readings
// Notes:   expectations worked by hand for step 5 and two readings
`timescale 1ns/100ps
module rfr_reading_filter_tb_top;
  logic              core_clk, rst_n, setupUnlocked, offsetLoad, sampleReady, fillDigits;
  logic              stepBtn, changeBtn, acceptBtn, sampleValid, filterTypeSel;
  logic              displaySourceSel, displayValid, analogValid, offsetFlash;
  logic [2:0]        menuState, pointPosition, roundingStep, averagingDepth;
  logic [1:0]        analogOutSourceSel;
  logic [7:0]        errorCode;
  logic signed [23:0] sampleData, readingOffsetValue, offsetScaled, displayValue, analogValue;
  logic signed [23:0] lastDisp, lastAna;
  int                compares, num_errors, dispCount;

  rfr_reading_filter dut (
    .core_clk(core_clk), .rst_n(rst_n), .stepBtn(stepBtn), .changeBtn(changeBtn),
    .acceptBtn(acceptBtn), .setupUnlocked(setupUnlocked), .sampleValid(sampleValid),
    .sampleData(sampleData), .sampleReady(sampleReady), .offsetLoad(offsetLoad),
    .readingOffsetValue(readingOffsetValue), .menuState(menuState),
    .fillDigits(fillDigits), .pointPosition(pointPosition), .roundingStep(roundingStep),
    .filterTypeSel(filterTypeSel), .displaySourceSel(displaySourceSel),
    .analogOutSourceSel(analogOutSourceSel), .averagingDepth(averagingDepth),
    .errorCode(errorCode), .offsetFlash(offsetFlash), .offsetScaled(offsetScaled),
    .displayValid(displayValid), .displayValue(displayValue),
    .analogValid(analogValid), .analogValue(analogValue));
  rfr_panel_model panel (.core_clk(core_clk), .sampleReady(sampleReady),
    .stepBtn(stepBtn), .changeBtn(changeBtn), .acceptBtn(acceptBtn),
    .sampleValid(sampleValid), .sampleData(sampleData));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // keep the latest outputs and count display pulses
  always @(posedge core_clk) begin
    if (displayValid === 1'b1) begin
      lastDisp  <= displayValue;
      dispCount <= dispCount + 1;
    end
    if (analogValid === 1'b1) begin
      lastAna <= analogValue;
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // offset load pulse, answer on the next edge
  task automatic load_offset(input logic signed [23:0] v);
    @(posedge core_clk);
    #2;
    readingOffsetValue = v;
    offsetLoad = 1'b1;
    @(posedge core_clk);
    #2;
    offsetLoad = 1'b0;
    @(posedge core_clk);
    #2;
  endtask : load_offset

  // a hang is cut short well past the expected run
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {rst_n, setupUnlocked, offsetLoad} = 3'h0;
    readingOffsetValue = '0;
    repeat (6) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    @(posedge core_clk);
    #2;
    check(pointPosition, 3'h0);
    check(roundingStep, 3'h0);
    check(filterTypeSel, 1'b0);
    check(displaySourceSel, 1'b1);
    check(analogOutSourceSel, 2'h1);
    check(averagingDepth, 3'h6);
    load_offset(24'sd1000000);
    check(errorCode, 8'h01);
    load_offset(24'sd5);
    check(errorCode, 8'h00);
    // point menu: fill, move twice, store
    panel.press(2);
    check(menuState, rfr_pkg::RFR_POINT);
    panel.press(0);
    check(fillDigits, 1'b1);
    panel.press(1);
    panel.press(1);
    panel.press(2);
    check(pointPosition, 3'h2);
    check(offsetScaled, 24'sd500);
    // count-by: show 2, 5 then pick 5
    panel.press(0);
    panel.press(0);
    panel.press(1);
    panel.press(2);
    check(roundingStep, 3'h2);
    check(menuState, rfr_pkg::RFR_FILT);
    // moving average, analog shows peak
    panel.press(1);
    panel.press(0);
    panel.press(0);
    panel.press(1);
    panel.press(2);
    check(filterTypeSel, 1'b1);
    check(analogOutSourceSel, 2'h2);
    // depth 6 -> 7 -> 0 -> 1, two readings
    for (int i = 0; i < 3; i++) panel.press(0);
    panel.press(1);
    panel.press(2);
    check(averagingDepth, 3'h1);
    check(menuState, rfr_pkg::RFR_RESET);
    panel.press(2);
    panel.send(24'sd101);
    panel.send(24'sd112);
    repeat (8) @(posedge core_clk);
    check(lastDisp, 24'sd105);
    check(lastAna, 24'sd112);
    panel.send(24'sd90);
    repeat (8) @(posedge core_clk);
    check(lastDisp, 24'sd100);
    check(dispCount, 2);
    load_offset(24'sd999999);
    // fill the buffer inside a menu, move the point once, walk back through setpoints
    setupUnlocked = 1'b1;
    panel.press(2);
    for (int i = 0; i < 32; i++) panel.send(24'(40 + i));
    repeat (2) @(posedge core_clk);
    check(sampleReady, 1'b0);
    panel.press(1);
    for (int i = 0; i < 6; i++) begin
      panel.press(2);
      if (i == 3)
        check(menuState, rfr_pkg::RFR_SETPT);
    end
    repeat (45) @(posedge core_clk);
    check(lastAna, 24'sd71);
    check(lastDisp, 24'sd70);
    check(pointPosition, 3'h3);
    check(offsetScaled, 24'sd999999);
    check(offsetFlash, 1'b1);
    // adaptive filter, raw display, filtered analog; a jump must drop the averaging
    for (int i = 0; i < 3; i++) panel.press(2);
    panel.press(1);
    panel.press(0);
    panel.press(1);
    panel.press(0);
    for (int i = 0; i < 3; i++) panel.press(1);
    for (int i = 0; i < 4; i++) panel.press(2);
    check(filterTypeSel, 1'b0);
    check(displaySourceSel, 1'b0);
    check(analogOutSourceSel, 2'h1);
    panel.send(24'sd200);
    panel.send(24'sd204);
    repeat (8) @(posedge core_clk);
    check(lastDisp, 24'sd205);
    check(lastAna, 24'sd202);
    panel.send(24'sd500);
    repeat (8) @(posedge core_clk);
    check(lastAna, 24'sd500);
    tally_and_finish();
  end
endmodule : rfr_reading_filter_tb_top
